// ### hdl/xfer_service.sv
`timescale 1ns/1ps
module xfer_service (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic trigger,
   input wire logic cpu_halted,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   output logic [7:0] sfr_addr,
   output logic [15:0] sfr_wdata,
   output logic sfr_we,
   output logic sfr_word,
   input wire logic [15:0] sfr_rdata,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic mem_we,
   output logic mem_word,
   input wire logic [15:0] mem_rdata,
   output logic vector_irq,
   output logic pattern_irq,
   output logic busy
);
   // =====================================
   // engine states
   typedef enum logic [2:0] {
      st_idle,
      st_rd,
      st_wr,
      st_mul,
      st_count
   } state_t;

   state_t state_ff;
   logic [31:0] ctrl_ff;
   logic [15:0] service_down_counter_ff;
   logic armed_ff;
   logic [23:0] ptr_ff;
   logic [15:0] coef_ff;
   logic [63:0] cmp_ff;
   logic [63:0] tape_index_pattern_ff;
   logic [7:0] mem_ptr_ff;
   logic [3:0] step_ff;
   logic halt_meta_ff;
   logic halt_sync_ff;
   logic vector_irq_ff;
   logic pattern_irq_ff;
   logic match_seen_ff;
   xfer_service_pkg::xfer_t xfer_ff;
   logic [31:0] reg_rdata_ff;

   xfer_service_pkg::mode_t mode;
   logic exch;
   logic to_mem;
   logic word_sel;
   logic mult_en;
   logic [1:0] npts;
   logic [3:0] last_step;
   logic trig_take;
   logic [31:0] product;
   logic [63:0] nxt_pattern;

   assign mode = xfer_service_pkg::mode_t'(ctrl_ff[xfer_service_pkg::ctrl_mode_lsb +: 2]);
   assign exch = ctrl_ff[xfer_service_pkg::ctrl_exch_bit];
   assign to_mem = ctrl_ff[xfer_service_pkg::ctrl_dir_bit];
   assign word_sel = ctrl_ff[xfer_service_pkg::ctrl_word_bit];
   assign mult_en = ctrl_ff[xfer_service_pkg::ctrl_mult_bit];
   assign npts = ctrl_ff[xfer_service_pkg::ctrl_npts_lsb +: 2];
   // full product kept, only its low half reaches the target sfr
   assign product = sfr_rdata * coef_ff;
   assign nxt_pattern = {tape_index_pattern_ff[62:0], sfr_rdata[xfer_service_pkg::pat_bit]};

   // compound walks four paths, each with npts items (zero counts as one)
   function automatic logic [3:0] steps_for(input xfer_service_pkg::mode_t m,
      input logic [1:0] n);
      logic [1:0] k;
      k = (n == 2'h0) ? 2'h1 : n;
      if (m == xfer_service_pkg::mode_compound) begin
         steps_for = {k, 2'h0} - 4'h1;
      end else begin
         steps_for = 4'h0;
      end
   endfunction

   // one decode for the write hits outside the main register case
   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = reg_we && reg_addr == off;
   endfunction

   assign last_step = steps_for(mode, npts);
   // trigger is same-clock logic from the interrupt controller;
   // cpu_halted is only reported, the engine runs on ref_clk regardless
   // a trigger still high when a step ends starts the next one
   assign trig_take = trigger && state_ff == st_idle && armed_ff;
   assign busy = state_ff != st_idle;

   // =====================================
   // register writes
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= xfer_service_pkg::ctrl_rst;
         ptr_ff <= 24'h000000;
         coef_ff <= 16'h0000;
         cmp_ff <= 64'h0000_0000_0000_0000;
         mem_ptr_ff <= 8'h00;
      end else if (reg_we) begin
         unique case (reg_addr)
            xfer_service_pkg::ctrl_off: ctrl_ff <= reg_wdata;
            xfer_service_pkg::ptr_off: ptr_ff <= reg_wdata[23:0];
            xfer_service_pkg::coef_off: coef_ff <= reg_wdata[15:0];
            xfer_service_pkg::cmp_lo_off: cmp_ff[31:0] <= reg_wdata;
            xfer_service_pkg::cmp_hi_off: cmp_ff[63:32] <= reg_wdata;
            xfer_service_pkg::mem_ptr_off: mem_ptr_ff <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // =====================================
   // counter and arming
   // a count write beside a decrement wins: software re-arm has priority
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         service_down_counter_ff <= xfer_service_pkg::count_rst;
         armed_ff <= 1'b0;
      end else if (wr_hit(xfer_service_pkg::count_off)) begin
         service_down_counter_ff <= reg_wdata[15:0];
         armed_ff <= reg_wdata[15:0] != 16'h0000;
      end else if (state_ff == st_count) begin
         service_down_counter_ff <= service_down_counter_ff - 16'h0001;
         if (service_down_counter_ff == 16'h0001) begin
            armed_ff <= 1'b0;
         end
      end
   end

   // =====================================
   // interrupt outputs: one-cycle pulses
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         vector_irq_ff <= 1'b0;
         pattern_irq_ff <= 1'b0;
      end else begin
         vector_irq_ff <= state_ff == st_count && service_down_counter_ff == 16'h0001;
         pattern_irq_ff <= state_ff == st_count && match_seen_ff;
      end
   end
   assign vector_irq = vector_irq_ff;
   assign pattern_irq = pattern_irq_ff;

   // =====================================
   // transfer engine, no cpu context touched
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= st_idle;
         step_ff <= 4'h0;
         tape_index_pattern_ff <= 64'h0000_0000_0000_0000;
         match_seen_ff <= 1'b0;
         xfer_ff <= '0;
      end else begin
         // write strobes are one-cycle pulses unless a state raises them
         xfer_ff.mem_we <= 1'b0;
         xfer_ff.sfr_we <= 1'b0;
         if (wr_hit(xfer_service_pkg::buf_lo_off)) begin
            tape_index_pattern_ff[31:0] <= reg_wdata;
         end else if (wr_hit(xfer_service_pkg::buf_hi_off)) begin
            tape_index_pattern_ff[63:32] <= reg_wdata;
         end
         unique case (state_ff)
            st_idle: begin
               match_seen_ff <= 1'b0;
               step_ff <= 4'h0;
               if (trig_take) begin
                  state_ff <= (mode == xfer_service_pkg::mode_counter) ? st_count : st_rd;
               end
            end
            st_rd: begin
               // present addresses; data return next cycle
               // compound sfr addresses wrap over the four paths only
               xfer_ff.sfr_addr <= (mode == xfer_service_pkg::mode_pattern)
                  ? ptr_ff[7:0] : ptr_ff[7:0] + {6'h00, step_ff[1:0]};
               xfer_ff.mem_addr <= (mode == xfer_service_pkg::mode_single)
                  ? (xfer_service_pkg::fast_win_base | {8'h00, mem_ptr_ff})
                  : {8'h00, mem_ptr_ff} + {12'h000, step_ff};
               // compound paths: 0 byte->mem, 1 word->mem, 2 mem->byte, 3 mem->word
               xfer_ff.word <= (mode == xfer_service_pkg::mode_compound)
                  ? step_ff[0] : word_sel;
               state_ff <= st_wr;
            end
            st_wr: begin
               unique case (mode)
                  xfer_service_pkg::mode_compound: begin
                     if (exch) begin
                        xfer_ff.mem_we <= 1'b1;
                        xfer_ff.sfr_we <= 1'b1;
                     end else begin
                        xfer_ff.mem_we <= !step_ff[1];
                        xfer_ff.sfr_we <= step_ff[1];
                     end
                     xfer_ff.mem_wdata <= sfr_rdata;
                     xfer_ff.sfr_wdata <= mem_rdata;
                  end
                  xfer_service_pkg::mode_single: begin
                     xfer_ff.mem_we <= to_mem;
                     xfer_ff.sfr_we <= !to_mem;
                     xfer_ff.mem_wdata <= sfr_rdata;
                     xfer_ff.sfr_wdata <= mem_rdata;
                  end
                  default: begin // pattern
                     tape_index_pattern_ff <= nxt_pattern;
                     match_seen_ff <= nxt_pattern == cmp_ff;
                  end
               endcase
               if (mode == xfer_service_pkg::mode_pattern && mult_en) begin
                  xfer_ff.sfr_addr <= ptr_ff[15:8];
                  state_ff <= st_mul;
               end else if (step_ff == last_step) begin
                  state_ff <= st_count;
               end else begin
                  step_ff <= step_ff + 4'h1;
                  state_ff <= st_rd;
               end
            end
            st_mul: begin
               // sfr_rdata now from pointer 1; low half kept
               xfer_ff.sfr_addr <= ptr_ff[23:16];
               xfer_ff.sfr_wdata <= product[15:0];
               xfer_ff.sfr_we <= 1'b1;
               xfer_ff.word <= 1'b1;
               state_ff <= st_count;
            end
            st_count: state_ff <= st_idle;
            default: state_ff <= st_idle;
         endcase
      end
   end

   assign sfr_addr = xfer_ff.sfr_addr;
   assign sfr_wdata = xfer_ff.sfr_wdata;
   assign sfr_we = xfer_ff.sfr_we;
   assign sfr_word = xfer_ff.word;
   assign mem_addr = xfer_ff.mem_addr;
   assign mem_wdata = xfer_ff.mem_wdata;
   assign mem_we = xfer_ff.mem_we;
   assign mem_word = xfer_ff.word;

   // =====================================
   // halt flag comes from the gated cpu side, so two flops first
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         halt_meta_ff <= 1'b0;
         halt_sync_ff <= 1'b0;
      end else begin
         halt_meta_ff <= cpu_halted;
         halt_sync_ff <= halt_meta_ff;
      end
   end

   // =====================================
   // register reads, data one cycle later
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_ff <= 32'h0000_0000;
      end else if (reg_re) begin
         unique case (reg_addr)
            xfer_service_pkg::ctrl_off: reg_rdata_ff <= ctrl_ff;
            xfer_service_pkg::count_off: reg_rdata_ff <= {16'h0000, service_down_counter_ff};
            xfer_service_pkg::status_off:
               reg_rdata_ff <= {28'h0000000, halt_sync_ff, match_seen_ff, busy, armed_ff};
            xfer_service_pkg::ptr_off: reg_rdata_ff <= {8'h00, ptr_ff};
            xfer_service_pkg::coef_off: reg_rdata_ff <= {16'h0000, coef_ff};
            xfer_service_pkg::cmp_lo_off: reg_rdata_ff <= cmp_ff[31:0];
            xfer_service_pkg::cmp_hi_off: reg_rdata_ff <= cmp_ff[63:32];
            xfer_service_pkg::buf_lo_off: reg_rdata_ff <= tape_index_pattern_ff[31:0];
            xfer_service_pkg::buf_hi_off: reg_rdata_ff <= tape_index_pattern_ff[63:32];
            xfer_service_pkg::mem_ptr_off: reg_rdata_ff <= {24'h000000, mem_ptr_ff};
            // unmapped offsets read as zero
            default: reg_rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_ff <= 32'h0000_0000;
      end
   end
   assign reg_rdata = reg_rdata_ff;
endmodule

// ### hdl/xfer_service_pkg.sv
package xfer_service_pkg;
   // =====================================
   // register map (word index = byte offset / 4)
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] count_off = 8'h04;
   localparam logic [7:0] status_off = 8'h08;
   localparam logic [7:0] ptr_off = 8'h0c;
   localparam logic [7:0] coef_off = 8'h10;
   localparam logic [7:0] cmp_lo_off = 8'h14;
   localparam logic [7:0] cmp_hi_off = 8'h18;
   localparam logic [7:0] buf_lo_off = 8'h1c;
   localparam logic [7:0] buf_hi_off = 8'h20;
   localparam logic [7:0] mem_ptr_off = 8'h24;
   // =====================================
   // field positions
   localparam int ctrl_mode_lsb = 0;
   localparam int ctrl_exch_bit = 2;
   localparam int ctrl_dir_bit = 3;
   localparam int ctrl_word_bit = 4;
   localparam int ctrl_mult_bit = 5;
   localparam int ctrl_npts_lsb = 6;
   localparam int pat_bit = 7;
   localparam int max_points = 3;
   localparam int cmp_bytes = 8;
   // =====================================
   // reset values and windows
   localparam logic [15:0] fast_win_base = 16'hfe00;
   localparam logic [31:0] ctrl_rst = 32'h0000_0000;
   localparam logic [15:0] count_rst = 16'h0000;
   localparam logic [7:0] unmapped_val = 8'h00;

   typedef enum logic [1:0] {
      mode_counter,
      mode_compound,
      mode_single,
      mode_pattern
   } mode_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   // one memory / sfr access of the engine
   typedef struct packed {
      logic mem_we;
      logic [15:0] mem_addr;
      logic [15:0] mem_wdata;
      logic sfr_we;
      logic [7:0] sfr_addr;
      logic [15:0] sfr_wdata;
      logic word;
   } xfer_t;
endpackage

// ### testbench/sfr_mem_model.sv
`timescale 1ns/1ps
module sfr_mem_model (
   input wire logic ref_clk,
   input wire logic [7:0] sfr_addr,
   input wire logic [15:0] sfr_wdata,
   input wire logic sfr_we,
   output logic [15:0] sfr_rdata,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic mem_we,
   output logic [15:0] mem_rdata
);
   logic [15:0] sfr [256];
   logic [15:0] mem [256];
   // memory folds on the low address byte: small model, aliasing is accepted
   assign sfr_rdata = sfr[sfr_addr];
   assign mem_rdata = mem[mem_addr[7:0]];
   always @(posedge ref_clk) begin
      if (sfr_we) sfr[sfr_addr] <= sfr_wdata;
      if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
   end
endmodule

// ### testbench/xfer_service_props.sv
`timescale 1ns/1ps
module xfer_service_props (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic trigger,
   input wire logic reg_re,
   input wire logic [31:0] reg_rdata,
   input wire logic sfr_we,
   input wire logic mem_we,
   input wire logic vector_irq,
   input wire logic pattern_irq,
   input wire logic busy
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // ==========
   // service steps
   a_step_after_trigger: assert property ($rose(busy) |-> $past(trigger))
      else $error("step without trigger");
   a_step_bounded: assert property ($rose(busy) |-> ##[1:40] !busy)
      else $error("step too long");
   a_mem_in_step: assert property (mem_we |-> busy || $past(busy))
      else $error("memory write outside step");
   a_mem_write_pulse: assert property (mem_we |=> !mem_we)
      else $error("memory write too long");
   a_sfr_write_pulse: assert property (sfr_we |=> !sfr_we)
      else $error("sfr write too long");
   // ==========
   // interrupts and reads
   a_vec_pulse: assert property (vector_irq |=> !vector_irq)
      else $error("vector pulse too long");
   a_vec_in_step: assert property (vector_irq |-> $past(busy) || $past(busy, 2))
      else $error("vector without step");
   a_match_pulse: assert property (pattern_irq |=> !pattern_irq)
      else $error("match pulse too long");
   a_read_idle_zero: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
      else $error("read data outside slot");
   c_vector: cover property (vector_irq);
   c_match: cover property (pattern_irq);
   c_long_step: cover property (busy [*8]);
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
`define chk(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   logic ref_clk, rstn, trigger, cpu_halted, reg_we, reg_re, sfr_we, mem_we;
   logic vector_irq, pattern_irq, busy, win_chk, sfr_word, mem_word, word_chk, word_exp;
   logic [7:0] reg_addr, sfr_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic [15:0] sfr_wdata, sfr_rdata, mem_addr, mem_wdata, mem_rdata, v, w, c;
   logic [31:0] seed = 32'h0001_2db1;
   int fails, checks_done, n_vec, n_pat, n_mem, n_sfr;
   xfer_service dut (
      .ref_clk(ref_clk), .rstn(rstn), .trigger(trigger), .cpu_halted(cpu_halted),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
      .sfr_word(sfr_word), .sfr_rdata(sfr_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_we(mem_we), .mem_word(mem_word), .mem_rdata(mem_rdata), .vector_irq(vector_irq),
      .pattern_irq(pattern_irq), .busy(busy));
   sfr_mem_model sm (
      .ref_clk(ref_clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
      .sfr_rdata(sfr_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .mem_rdata(mem_rdata));
   function automatic logic [15:0] rnd16();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   function automatic logic [15:0] prod16(input logic [15:0] a, input logic [15:0] k);
      return a * k;
   endfunction
   // sfr->mem and mem->sfr writes per compound service; zero points serve one
   function automatic int cmp_writes(input int n, input int x);
      return 2 * ((n == 0) ? 1 : n) * (1 + x);
   endfunction
   // ==========
   // bus and trigger tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_re <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   // trigger held n cycles: the extra cycles land while busy
   task automatic trig(input int n);
      @(posedge ref_clk);
      trigger <= 1'b1;
      repeat (n) @(posedge ref_clk);
      trigger <= 1'b0;
      #1;
      while (busy) @(posedge ref_clk) #1;
      repeat (6) @(posedge ref_clk);
      #1;
   endtask
   task automatic clr();
      n_vec = 0;
      n_pat = 0;
      n_mem = 0;
      n_sfr = 0;
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      n_vec += vector_irq;
      n_pat += pattern_irq;
      n_mem += mem_we;
      n_sfr += sfr_we;
      if (mem_we && win_chk) `chk(mem_addr[15:8], 8'hfe)
      if ((mem_we || sfr_we) && word_chk) `chk(({sfr_word, mem_word}), ({2{word_exp}}))
   end
   initial begin
      #20000;
      fails++;
      wrap_up();
   end
   // ==========
   // main sequence
   initial begin
      {rstn, trigger, cpu_halted, reg_we, reg_re, win_chk, word_chk, word_exp} = 8'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      for (int i = 0; i < 256; i++) begin
         sm.sfr[i] = rnd16();
         sm.mem[i] = rnd16();
      end
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(xfer_service_pkg::ctrl_off);
      `chk(rd_val, xfer_service_pkg::ctrl_rst)
      rd(xfer_service_pkg::count_off);
      `chk(rd_val[15:0], xfer_service_pkg::count_rst)
      rd(8'h3c);
      `chk(rd_val, 32'h0)
      cpu_halted <= 1'b1;
      wr(xfer_service_pkg::count_off, 32'h2);
      trig(1);
      `chk(n_vec, 0)
      trig(1);
      trig(1);
      `chk(n_vec, 1)
      rd(xfer_service_pkg::status_off);
      `chk(rd_val[3:0], 4'h8)
      $display("counter test done");
      clr();
      wr(xfer_service_pkg::ptr_off, 32'h5);
      wr(xfer_service_pkg::mem_ptr_off, 32'h10);
      wr(xfer_service_pkg::ctrl_off, 32'ha);
      wr(xfer_service_pkg::count_off, 32'h3);
      v = sm.sfr[5];
      win_chk = 1'b1;
      word_exp = 1'b0;
      word_chk = 1'b1;
      trig(3);
      `chk(n_mem, 1)
      `chk(sm.mem[8'h10][7:0], v[7:0])
      repeat (3) trig(1);
      `chk(n_mem, 3)
      `chk(n_vec, 1)
      win_chk = 1'b0;
      word_exp = 1'b1;
      clr();
      wr(xfer_service_pkg::ptr_off, 32'h7);
      wr(xfer_service_pkg::mem_ptr_off, 32'h20);
      wr(xfer_service_pkg::ctrl_off, 32'h12);
      wr(xfer_service_pkg::count_off, 32'h1);
      v = sm.mem[8'h20];
      trig(1);
      `chk(sm.sfr[7], v)
      word_chk = 1'b0;
      $display("single test done");
      for (int n = 0; n < 4; n++) begin
         for (int x = 0; x < 2; x++) begin
            clr();
            wr(xfer_service_pkg::ptr_off, 32'h30);
            wr(xfer_service_pkg::mem_ptr_off, 32'h40);
            wr(xfer_service_pkg::ctrl_off, 32'((n << 6) | (x << 2) | 1));
            wr(xfer_service_pkg::count_off, 32'h1);
            v = sm.sfr[8'h30];
            w = sm.mem[8'h40];
            trig(1);
            `chk(n_mem, cmp_writes(n, x))
            `chk(n_sfr, cmp_writes(n, x))
            `chk(sm.mem[8'h40][7:0], v[7:0])
            if (x == 1 && n < 2) `chk(sm.sfr[8'h30][7:0], w[7:0])
            `chk(n_vec, 1)
         end
      end
      $display("compound test done");
      clr();
      sm.sfr[8'h50] = 16'h0080;
      c = rnd16();
      wr(xfer_service_pkg::ptr_off, 32'h0052_5150);
      wr(xfer_service_pkg::coef_off, {16'h0, c});
      wr(xfer_service_pkg::cmp_lo_off, 32'h1);
      wr(xfer_service_pkg::cmp_hi_off, 32'h1);
      wr(xfer_service_pkg::ctrl_off, 32'h23);
      wr(xfer_service_pkg::count_off, 32'h3);
      trig(1);
      `chk(n_pat, 0)
      `chk(sm.sfr[8'h52], prod16(sm.sfr[8'h51], c))
      wr(xfer_service_pkg::cmp_lo_off, 32'h3);
      wr(xfer_service_pkg::cmp_hi_off, 32'h0);
      trig(1);
      `chk(n_pat, 1)
      rd(xfer_service_pkg::buf_lo_off);
      `chk(rd_val, 32'h3)
      wr(xfer_service_pkg::ctrl_off, 32'h3);
      w = sm.sfr[8'h52];
      trig(1);
      `chk(sm.sfr[8'h52], w)
      `chk(n_vec, 1)
      $display("pattern test done");
      wrap_up();
   end
endmodule
bind xfer_service xfer_service_props u_props (
   .ref_clk(ref_clk), .rstn(rstn), .trigger(trigger), .reg_re(reg_re),
   .reg_rdata(reg_rdata), .sfr_we(sfr_we), .mem_we(mem_we), .vector_irq(vector_irq),
   .pattern_irq(pattern_irq), .busy(busy));
